// *** shared/wow_defines.svh ***
`ifndef WOW_DEFINES_SVH
`define WOW_DEFINES_SVH

// register indices; byte address is four times the index
`define WOW_IDX_OPT_TWO 16'h001e
`define WOW_IDX_OPT_ONE 16'h001f
`define WOW_IDX_SERVICE 16'hffff
`define WOW_IDX_CAUSE 16'h0020
`define WOW_IDX_WD_STAT 16'h0021

`define WOW_OPT_RESET 8'h00
`define WOW_CAUSE_RESET 4'h0

// option_register_two fields
`define WOW_B2_TB_DIV 0
`define WOW_B2_OSC_STOP 1
`define WOW_B2_BAUD_SRC 2

// option_register_one fields
`define WOW_B1_WD_DISABLE 0
`define WOW_B1_STOP_EN 1
`define WOW_B1_SHORT_REC 2
`define WOW_B1_VMODE 3
`define WOW_B1_DET_PWRD 4
`define WOW_B1_DET_RSTD 5
`define WOW_B1_DET_STOP 6
`define WOW_B1_WD_RATE 7

// reset cause fields
`define WOW_C_WATCHDOG 0
`define WOW_C_ILLEGAL 1
`define WOW_C_DETECTOR 2
`define WOW_C_PIN 3

// timing counts in oscillator clock cycles
`define WOW_STOP_SHORT_CYC 13'd32
`define WOW_STOP_LONG_CYC 13'd4096
`define WOW_POR_CLR_CYC 13'd4096
`define WOW_PIN_HOLD_CYC 6'd32
`define WOW_PIN_GUARD_CYC 6'd3
`define WOW_TB_DIV_MAX 7'd127

// prescaler taps that advance the watchdog counter, and prescaler bits kept on service
`define WOW_TAP_FAST 6
`define WOW_TAP_SLOW 11
`define WOW_SERVICE_KEEP 12'h000f

`endif

// *** shared/wow_pkg.sv ***
package wow_pkg;

    typedef enum logic [2:0] {
        WOW_ST_RUN = 3'b001,
        WOW_ST_STOPPED = 3'b010,
        WOW_ST_RECOVER = 3'b100
    } wow_stop_state_t;

    typedef enum logic [1:0] {
        WOW_RESP_OKAY = 2'b00,
        WOW_RESP_SLVERR = 2'b10
    } wow_resp_t;

endpackage

// *** rtl/wow_top.sv ***
// Functional notes
// - option registers take one write per reset
// - internal reset clears options except voltage mode
// - options at two consecutive indices, always readable
// - voltage mode: cleared, write-once only per power-on
// - timebase select inserts divide-by-128 prescaler
// - oscillator keeps running in stop when set
// - baud source: bus clock or oscillator
// - rate select picks short or long timeout
// - detector runs in stop if set, powered
// - reset-disable blocks detector resets
// - power-disable powers detector down
// - voltage mode selects 5-V or 3-V
// - short recovery 32 cycles, else 4096
// - detector-reset stop exit uses long recovery
// - disabled stop instruction is illegal opcode
// - watchdog disable bit suppresses watchdog reset
// - 6-bit counter after 12-bit prescaler, overflow resets
// - watchdog reset drives pin 32 cycles, flags cause
// - stop and vector fetch clear prescaler
// - internal reset clears all; power-on clears prescaler
// - watchdog counts in wait, never interrupts
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "wow_defines.svh"
`default_nettype none

module wow_top #(
    parameter int ADDR_W = 18,
    parameter int PRE_W = 12,
    parameter int CNT_W = 6
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stop_instr,
    input wire logic wake_req,
    input wire logic reset_vector_fetch,
    input wire logic [7:0] reset_vector_low,
    input wire logic bus_clock_tick,
    input wire logic detector_reset_req,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_b,
    output logic internal_reset,
    output logic illegal_opcode,
    output logic stop_mode,
    output logic stop_exit,
    output logic osc_enable,
    output logic timebase_tick,
    output logic serial_tick,
    output logic detector_power_on,
    output logic detector_enable,
    output logic detector_5v_mode
);

    generate
        if (ADDR_W < 18 || ADDR_W > 32 || PRE_W != 12 || CNT_W != 6)
        begin : g_bad
            $error("wow_top: unsupported parameter values");
        end
    endgenerate

    // ---------------- bus slave ----------------
    logic aw_held_reg, aw_held_next;
    logic [15:0] aw_idx_reg, aw_idx_next;
    logic w_held_reg, w_held_next;
    logic [7:0] w_byte_reg, w_byte_next;
    logic w_lane_reg, w_lane_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic rvalid_reg, rvalid_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic arready_reg, arready_next;
    logic wr_do;
    logic rd_do;
    logic [15:0] ar_idx;

    // option and cause state
    logic [7:0] opt_two_reg, opt_two_next;
    logic [7:0] opt_one_reg, opt_one_next;
    logic two_lock_reg, two_lock_next;
    logic one_lock_reg, one_lock_next;
    logic vm_lock_reg, vm_lock_next;
    logic [3:0] cause_reg, cause_next;
    logic [3:0] cause_set;
    logic [3:0] cause_clr;
    logic service_wr;

    // watchdog
    logic [PRE_W-1:0] pre_reg, pre_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [12:0] por_cnt_reg, por_cnt_next;
    logic por_done_reg, por_done_next;
    logic wd_ovf;
    logic wd_carry;

    // stop, reset and pin
    wow_pkg::wow_stop_state_t st_reg, st_next;
    logic [12:0] rec_cnt_reg, rec_cnt_next;
    logic pend_det_reg, pend_det_next;
    logic [5:0] hold_reg, hold_next;
    logic pin_meta_reg, pin_sync_reg;
    logic [6:0] tb_div_reg, tb_div_next;
    logic irst_reg, irst_next;
    logic illegal_reg, illegal_next;
    logic exit_reg, exit_next;
    logic stop_ok;
    logic det_ok;
    logic det_now;
    logic pin_rst;
    logic rec_end;
    logic [12:0] rec_len;

    // derived outputs
    logic pin_oe_b_reg, pin_oe_b_next;
    logic stop_mode_reg, stop_mode_next;
    logic osc_en_reg, osc_en_next;
    logic tb_tick_reg, tb_tick_next;
    logic ser_tick_reg, ser_tick_next;
    logic det_pwr_reg, det_pwr_next;
    logic det_en_reg, det_en_next;
    logic det_5v_reg, det_5v_next;

    assign wr_do = aw_held_reg && w_held_reg && !bvalid_reg;
    assign rd_do = s_axi_arvalid && arready_reg;
    assign ar_idx = s_axi_araddr[17:2];
    assign service_wr = wr_do && (aw_idx_reg == `WOW_IDX_SERVICE);

    always_comb
    begin
        aw_held_next = aw_held_reg;
        aw_idx_next = aw_idx_reg;
        w_held_next = w_held_reg;
        w_byte_next = w_byte_reg;
        w_lane_next = w_lane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && awready_reg)
        begin
            aw_held_next = 1'b1;
            aw_idx_next = s_axi_awaddr[17:2];
        end
        if (s_axi_wvalid && wready_reg)
        begin
            w_held_next = 1'b1;
            w_byte_next = s_axi_wdata[7:0];
            w_lane_next = s_axi_wstrb[0];
        end
        if (bvalid_reg && s_axi_bready)
            bvalid_next = 1'b0;
        if (wr_do)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            case (aw_idx_reg)
                `WOW_IDX_OPT_TWO, `WOW_IDX_OPT_ONE, `WOW_IDX_SERVICE, `WOW_IDX_CAUSE,
                `WOW_IDX_WD_STAT: bresp_next = wow_pkg::WOW_RESP_OKAY;
                default: bresp_next = wow_pkg::WOW_RESP_SLVERR;
            endcase
        end
        awready_next = !aw_held_next && !bvalid_next;
        wready_next = !w_held_next && !bvalid_next;
    end

    // reads have no side effect except clearing the cause bits returned
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        cause_clr = 4'h0;
        if (rvalid_reg && s_axi_rready)
            rvalid_next = 1'b0;
        if (rd_do)
        begin
            rvalid_next = 1'b1;
            rresp_next = wow_pkg::WOW_RESP_OKAY;
            rdata_next = 32'h0000_0000;
            case (ar_idx)
                `WOW_IDX_OPT_TWO: rdata_next[7:0] = opt_two_reg;
                `WOW_IDX_OPT_ONE: rdata_next[7:0] = opt_one_reg;
                `WOW_IDX_SERVICE: rdata_next[7:0] = reset_vector_low;
                `WOW_IDX_CAUSE:
                begin
                    rdata_next[3:0] = cause_reg;
                    cause_clr = cause_reg;
                end
                `WOW_IDX_WD_STAT: rdata_next[CNT_W-1:0] = cnt_reg;
                default: rresp_next = wow_pkg::WOW_RESP_SLVERR;
            endcase
        end
        arready_next = !rvalid_next;
    end

    // write-once options
    always_comb
    begin
        opt_two_next = opt_two_reg;
        opt_one_next = opt_one_reg;
        two_lock_next = two_lock_reg;
        one_lock_next = one_lock_reg;
        vm_lock_next = vm_lock_reg;
        if (irst_reg)
        begin
            opt_two_next = `WOW_OPT_RESET;
            opt_one_next = `WOW_OPT_RESET;
            opt_one_next[`WOW_B1_VMODE] = opt_one_reg[`WOW_B1_VMODE];
            two_lock_next = 1'b0;
            one_lock_next = 1'b0;
        end
        else if (wr_do && w_lane_reg)
        begin
            if (aw_idx_reg == `WOW_IDX_OPT_TWO && !two_lock_reg)
            begin
                opt_two_next = w_byte_reg;
                two_lock_next = 1'b1;
            end
            if (aw_idx_reg == `WOW_IDX_OPT_ONE)
            begin
                if (!one_lock_reg)
                begin
                    opt_one_next = w_byte_reg;
                    opt_one_next[`WOW_B1_VMODE] = opt_one_reg[`WOW_B1_VMODE];
                    one_lock_next = 1'b1;
                end
                if (!vm_lock_reg)
                begin
                    opt_one_next[`WOW_B1_VMODE] = w_byte_reg[`WOW_B1_VMODE];
                    vm_lock_next = 1'b1;
                end
            end
        end
    end

    // watchdog prescaler and counter
    assign wd_carry = opt_one_reg[`WOW_B1_WD_RATE] ? (&pre_reg[`WOW_TAP_FAST:0])
        : (&pre_reg[`WOW_TAP_SLOW:0]);

    always_comb
    begin
        pre_next = pre_reg;
        cnt_next = cnt_reg;
        por_cnt_next = por_cnt_reg;
        por_done_next = por_done_reg;
        wd_ovf = 1'b0;
        if (!por_done_reg)
            por_cnt_next = por_cnt_reg + 13'd1;
        if (!por_done_reg && por_cnt_reg == `WOW_POR_CLR_CYC - 13'd1)
            por_done_next = 1'b1;
        if (irst_reg || opt_one_reg[`WOW_B1_WD_DISABLE])
        begin
            pre_next = '0;
            cnt_next = '0;
        end
        else if (stop_ok || reset_vector_fetch || (por_done_next && !por_done_reg))
            pre_next = '0;
        else if (stop_mode_reg)
            pre_next = pre_reg; // clock to the watchdog is off in stop
        else if (service_wr)
        begin
            cnt_next = '0;
            pre_next = pre_reg & `WOW_SERVICE_KEEP;
        end
        else
        begin
            // keeps counting in wait mode; only a reset comes out
            pre_next = pre_reg + 12'd1;
            if (wd_carry)
            begin
                cnt_next = cnt_reg + 6'd1;
                wd_ovf = &cnt_reg;
            end
        end
    end

    // stop sequencing
    assign stop_ok = stop_instr && opt_one_reg[`WOW_B1_STOP_EN] && st_reg == wow_pkg::WOW_ST_RUN;
    assign det_ok = detector_reset_req && !opt_one_reg[`WOW_B1_DET_RSTD];
    assign det_now = det_ok && st_reg == wow_pkg::WOW_ST_RUN;
    assign rec_end = st_reg == wow_pkg::WOW_ST_RECOVER && rec_cnt_reg == 13'd1;
    assign rec_len = (opt_one_reg[`WOW_B1_SHORT_REC] && !det_ok) ? `WOW_STOP_SHORT_CYC
        : `WOW_STOP_LONG_CYC;
    assign pin_rst = !pin_sync_reg && hold_reg == 6'd0;

    always_comb
    begin
        st_next = st_reg;
        rec_cnt_next = rec_cnt_reg;
        pend_det_next = pend_det_reg;
        exit_next = 1'b0;
        case (st_reg)
            wow_pkg::WOW_ST_RUN:
            begin
                if (stop_ok)
                    st_next = wow_pkg::WOW_ST_STOPPED;
            end
            wow_pkg::WOW_ST_STOPPED:
            begin
                if (det_ok || wake_req)
                begin
                    st_next = wow_pkg::WOW_ST_RECOVER;
                    rec_cnt_next = rec_len;
                    pend_det_next = det_ok;
                end
            end
            wow_pkg::WOW_ST_RECOVER:
            begin
                rec_cnt_next = rec_cnt_reg - 13'd1;
                if (rec_end)
                begin
                    st_next = wow_pkg::WOW_ST_RUN;
                    exit_next = 1'b1;
                    pend_det_next = 1'b0;
                end
            end
            default: st_next = wow_pkg::WOW_ST_RUN;
        endcase
        if (irst_reg && st_reg != wow_pkg::WOW_ST_RECOVER)
        begin
            st_next = wow_pkg::WOW_ST_RUN;
            pend_det_next = 1'b0;
        end
    end

    // reset sources, cause flags and reset pin
    always_comb
    begin
        illegal_next = stop_instr && !opt_one_reg[`WOW_B1_STOP_EN];
        cause_set = 4'h0;
        cause_set[`WOW_C_WATCHDOG] = wd_ovf;
        cause_set[`WOW_C_ILLEGAL] = illegal_next;
        cause_set[`WOW_C_DETECTOR] = det_now || (rec_end && pend_det_reg);
        cause_set[`WOW_C_PIN] = pin_rst;
        irst_next = |cause_set;
        cause_next = (cause_reg & ~cause_clr) | cause_set;
        hold_next = hold_reg;
        if (irst_next && !pin_rst)
            hold_next = `WOW_PIN_HOLD_CYC + `WOW_PIN_GUARD_CYC;
        else if (hold_reg != 6'd0)
            hold_next = hold_reg - 6'd1;
        // guard cycles let the synchronised pin rise before it is watched again
        pin_oe_b_next = !(hold_next > `WOW_PIN_GUARD_CYC);
    end

    // option-driven outputs
    always_comb
    begin
        tb_div_next = (tb_div_reg == `WOW_TB_DIV_MAX) ? 7'd0 : tb_div_reg + 7'd1;
        stop_mode_next = st_next != wow_pkg::WOW_ST_RUN;
        osc_en_next = st_next != wow_pkg::WOW_ST_STOPPED
            || opt_two_reg[`WOW_B2_OSC_STOP];
        tb_tick_next = osc_en_next && (!opt_two_reg[`WOW_B2_TB_DIV]
            || tb_div_reg == `WOW_TB_DIV_MAX);
        ser_tick_next = opt_two_reg[`WOW_B2_BAUD_SRC] ? bus_clock_tick : osc_en_next;
        det_pwr_next = !opt_one_reg[`WOW_B1_DET_PWRD];
        det_en_next = det_pwr_next && (st_next != wow_pkg::WOW_ST_STOPPED
            || opt_one_reg[`WOW_B1_DET_STOP]);
        det_5v_next = opt_one_reg[`WOW_B1_VMODE];
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_held_reg <= 1'b0;
            aw_idx_reg <= 16'h0000;
            w_held_reg <= 1'b0;
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'h0;
            rdata_reg <= 32'h0000_0000;
            arready_reg <= 1'b0;
            opt_two_reg <= `WOW_OPT_RESET;
            opt_one_reg <= `WOW_OPT_RESET;
            two_lock_reg <= 1'b0;
            one_lock_reg <= 1'b0;
            vm_lock_reg <= 1'b0;
            cause_reg <= `WOW_CAUSE_RESET;
            pre_reg <= '0;
            cnt_reg <= '0;
            por_cnt_reg <= 13'h0000;
            por_done_reg <= 1'b0;
            st_reg <= wow_pkg::WOW_ST_RUN;
            rec_cnt_reg <= 13'h0000;
            pend_det_reg <= 1'b0;
            hold_reg <= 6'h00;
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
            tb_div_reg <= 7'h00;
            irst_reg <= 1'b0;
            illegal_reg <= 1'b0;
            exit_reg <= 1'b0;
            pin_oe_b_reg <= 1'b1;
            stop_mode_reg <= 1'b0;
            osc_en_reg <= 1'b1;
            tb_tick_reg <= 1'b0;
            ser_tick_reg <= 1'b0;
            det_pwr_reg <= 1'b1;
            det_en_reg <= 1'b1;
            det_5v_reg <= 1'b0;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            aw_idx_reg <= aw_idx_next;
            w_held_reg <= w_held_next;
            w_byte_reg <= w_byte_next;
            w_lane_reg <= w_lane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            arready_reg <= arready_next;
            opt_two_reg <= opt_two_next;
            opt_one_reg <= opt_one_next;
            two_lock_reg <= two_lock_next;
            one_lock_reg <= one_lock_next;
            vm_lock_reg <= vm_lock_next;
            cause_reg <= cause_next;
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            por_cnt_reg <= por_cnt_next;
            por_done_reg <= por_done_next;
            st_reg <= st_next;
            rec_cnt_reg <= rec_cnt_next;
            pend_det_reg <= pend_det_next;
            hold_reg <= hold_next;
            pin_meta_reg <= reset_pin_in;
            pin_sync_reg <= pin_meta_reg;
            tb_div_reg <= tb_div_next;
            irst_reg <= irst_next;
            illegal_reg <= illegal_next;
            exit_reg <= exit_next;
            pin_oe_b_reg <= pin_oe_b_next;
            stop_mode_reg <= stop_mode_next;
            osc_en_reg <= osc_en_next;
            tb_tick_reg <= tb_tick_next;
            ser_tick_reg <= ser_tick_next;
            det_pwr_reg <= det_pwr_next;
            det_en_reg <= det_en_next;
            det_5v_reg <= det_5v_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign reset_pin_out = 1'b0 & pin_oe_b_reg;
    assign reset_pin_oe_b = pin_oe_b_reg;
    assign internal_reset = irst_reg;
    assign illegal_opcode = illegal_reg;
    assign stop_mode = stop_mode_reg;
    assign stop_exit = exit_reg;
    assign osc_enable = osc_en_reg;
    assign timebase_tick = tb_tick_reg;
    assign serial_tick = ser_tick_reg;
    assign detector_power_on = det_pwr_reg;
    assign detector_enable = det_en_reg;
    assign detector_5v_mode = det_5v_reg;

endmodule

`default_nettype wire

// *** tb/wow_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module wow_top_assertions (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic stop_instr,
    input wire logic stop_mode,
    input wire logic illegal_opcode,
    input wire logic osc_enable,
    input wire logic timebase_tick,
    input wire logic internal_reset,
    input wire logic reset_pin_oe_b
);
    logic [5:0] low_reg;
    logic [5:0] low_next;
    // cycles of low drive on the reset pin
    always_comb
    begin
        low_next = reset_pin_oe_b ? 6'h00 : low_reg + 6'h01;
    end
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            low_reg <= 6'h00;
        else
            low_reg <= low_next;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_pin_hold_span: assert property ($rose(reset_pin_oe_b) |-> low_reg == 6'h20)
        else $error("reset pin low span wrong");
    a_pin_drive_start: assert property (internal_reset |-> !reset_pin_oe_b)
        else $error("reset pin not driven with internal reset");
    a_reset_one_pulse: assert property (internal_reset |=> !internal_reset)
        else $error("internal reset longer than one cycle");
    a_stop_or_illegal: assert property (stop_instr && !stop_mode && !internal_reset
        |=> stop_mode != illegal_opcode)
        else $error("stop instruction neither entered nor refused");
    a_illegal_cause: assert property (illegal_opcode |-> $past(stop_instr))
        else $error("illegal opcode without stop instruction");
    a_osc_outside_stop: assert property (!stop_mode |-> osc_enable)
        else $error("oscillator off outside stop");
    a_tick_osc_off: assert property (!osc_enable |-> !timebase_tick)
        else $error("timebase tick while oscillator off");
    a_b_one_beat: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during read answer");
endmodule
bind wow_top wow_top_assertions u_wow_top_assertions (.clock(clock), .rst_b(rst_b),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .stop_instr(stop_instr), .stop_mode(stop_mode),
    .illegal_opcode(illegal_opcode), .osc_enable(osc_enable), .timebase_tick(timebase_tick),
    .internal_reset(internal_reset), .reset_pin_oe_b(reset_pin_oe_b));
`default_nettype wire

// *** tb/wow_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module wow_core_model #(
    parameter logic [7:0] VEC_LOW = 8'h5a
) (
    input wire logic clock,
    input wire logic rst_b,
    output logic bus_clock_tick,
    output logic [7:0] reset_vector_low
);
    logic [1:0] div_reg;
    logic [1:0] div_next;
    always_comb
    begin
        div_next = div_reg + 2'h1;
    end
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            div_reg <= 2'h0;
        else
            div_reg <= div_next;
    end
    // bus clock runs at a quarter of the oscillator rate
    assign bus_clock_tick = div_reg == 2'h3;
    assign reset_vector_low = VEC_LOW;
endmodule
`default_nettype wire

// *** tb/wow_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "wow_defines.svh"
module wow_top_test;
    localparam logic [17:0] addr_two = {`WOW_IDX_OPT_TWO, 2'b00};
    localparam logic [17:0] addr_one = {`WOW_IDX_OPT_ONE, 2'b00};
    localparam logic [17:0] addr_svc = {`WOW_IDX_SERVICE, 2'b00};
    localparam logic [17:0] addr_cause = {`WOW_IDX_CAUSE, 2'b00};
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [17:0] s_axi_awaddr = 18'h0_0000;
    logic [17:0] s_axi_araddr = 18'h0_0000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stop_instr = 1'b0, wake_req = 1'b0;
    logic reset_vector_fetch = 1'b0, detector_reset_req = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [7:0] reset_vector_low;
    logic bus_clock_tick, reset_pin_in, reset_pin_out, reset_pin_oe_b, internal_reset;
    logic illegal_opcode, stop_mode, stop_exit, osc_enable, timebase_tick, serial_tick;
    logic detector_power_on, detector_enable, detector_5v_mode;
    int fails = 0;
    int compares = 0;
    int n;
    logic [7:0] v;
    logic [31:0] d;
    logic [1:0] r;
    // pulled-up reset pin
    assign reset_pin_in = reset_pin_oe_b ? 1'b1 : reset_pin_out;
    always #25 clock = ~clock;
    wow_core_model u_wow_core_model (.clock, .rst_b, .bus_clock_tick, .reset_vector_low);
    wow_top u_wow_top (.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_instr, .wake_req,
        .reset_vector_fetch, .reset_vector_low, .bus_clock_tick, .detector_reset_req,
        .reset_pin_in, .reset_pin_out, .reset_pin_oe_b, .internal_reset, .illegal_opcode,
        .stop_mode, .stop_exit, .osc_enable, .timebase_tick, .serial_tick,
        .detector_power_on, .detector_enable, .detector_5v_mode);
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [17:0] a, input logic [7:0] x);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, x};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [17:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // option one: voltage mode kept from the first write
    function logic [31:0] keep_mode(input logic [7:0] nv, input logic [7:0] ov);
        return {24'h00_0000, (nv & 8'hf7) | (ov & 8'h08)};
    endfunction
    task stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clock);
        fails++;
        stop_test;
    end
    initial
    begin
        n = $urandom(32'hc966);
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        rd(addr_two);
        chk(d, 32'h0000_0000, "opt two reset");
        rd(addr_one);
        chk(d, 32'h0000_0000, "opt one reset");
        wr(18'h0_0100, 8'h00);
        chk(32'(r), 32'h0000_0002, "unmapped write");
        rd(18'h0_0100);
        chk(32'(r), 32'h0000_0002, "unmapped read");
        rd(addr_svc);
        chk(d, 32'h0000_005a, "service read");
        v = (8'($urandom) & 8'h74) | 8'h89;
        wr(addr_one, v);
        wr(addr_one, ~v);
        rd(addr_one);
        chk(d, {24'h00_0000, v}, "opt one once");
        chk(32'({detector_power_on, detector_5v_mode}), 32'({~v[4], 1'b1}), "det");
        repeat (9000) @(posedge clock);
        rd(addr_one);
        chk(d, {24'h00_0000, v}, "disabled watchdog");
        $display("write once test done");
        @(posedge clock);
        stop_instr <= 1'b1;
        @(posedge clock);
        stop_instr <= 1'b0;
        repeat (40) @(posedge clock);
        rd(addr_one);
        chk(d, keep_mode(8'h00, v), "opt after reset");
        rd(addr_cause);
        chk(d, 32'h0000_0002, "cause illegal");
        wr(addr_one, 8'h86);
        wr(addr_two, 8'h02);
        rd(addr_one);
        chk(d, keep_mode(8'h86, v), "mode locked");
        $display("illegal stop test done");
        @(posedge clock);
        stop_instr <= 1'b1;
        @(posedge clock);
        stop_instr <= 1'b0;
        @(posedge clock);
        chk(32'(stop_mode), 32'h0000_0001, "stop entered");
        chk(32'(osc_enable), 32'h0000_0001, "osc in stop");
        chk(32'(detector_enable), 32'h0000_0000, "det stop");
        wake_req <= 1'b1;
        @(posedge clock);
        wake_req <= 1'b0;
        n = 0;
        while (!stop_exit && n < 200)
        begin
            @(posedge clock);
            n++;
        end
        chk(32'(n >= 30 && n <= 34), 32'h0000_0001, "short recovery");
        $display("stop test done");
        repeat (3)
        begin
            repeat (4000) @(posedge clock);
            wr(addr_svc, 8'($urandom));
        end
        rd(addr_one);
        chk(d, keep_mode(8'h86, v), "serviced");
        wr(addr_svc, 8'($urandom));
        n = 0;
        while (!internal_reset && n < 9000)
        begin
            @(posedge clock);
            n++;
        end
        chk(32'(n >= 8160 && n <= 8200), 32'h0000_0001, "timeout");
        repeat (40) @(posedge clock);
        rd(addr_cause);
        chk(d, 32'h0000_0001, "cause watchdog");
        $display("watchdog test done");
        stop_test;
    end
endmodule
`default_nettype wire
